// >>> logic/exec_unit.v
// Execution unit for return, rotate, literal-subtract and power-down operations.
`timescale 1ns/1ps
`include "exec_unit_defs.vh"
// Function
// RULE1: Subroutine exit pops stack into PC, two cycles.
// RULE2: Literal exit loads literal to accumulator, returns.
// RULE3: Rotate left through carry, only carry altered.
// RULE4: Rotate-left destination zero accumulator, one file.
// RULE5: Rotate right through carry, destination select.
// RULE6: Literal minus accumulator into accumulator, flags.
// RULE7: Carry and digit carry mean no borrow.
// RULE8: Power-down clears watchdog, prescaler, sets flags.
// RULE9: Power-down enters sleep, execution halts.
// RULE10: Rotate/subtract one cycle; zero flag on result.
module exec_unit #(
    parameter WIDTH   = 8,
    parameter PC_W    = 15,
    parameter WD_W    = 8,
    parameter PRE_W   = 8
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst_n,
    // Decoded instruction
    input  wire             instr_valid,
    input  wire [2:0]       instr_op,
    input  wire [WIDTH-1:0] instr_literal,
    input  wire [6:0]       instr_file_addr,
    input  wire             instr_dest,
    input  wire             instr_ready,
    // File register read data, stack top and wake event
    input  wire [WIDTH-1:0] file_rdata,
    input  wire [PC_W-1:0]  stack_top,
    input  wire             wake_event,
    // Status flags in
    input  wire             carry_in,
    // Results
    output reg  [WIDTH-1:0] acc_ff,
    output reg              carry_ff,
    output reg              digit_carry_ff,
    output reg              zero_ff,
    output reg              file_we_ff,
    output reg  [6:0]       file_waddr_ff,
    output reg  [WIDTH-1:0] file_wdata_ff,
    output reg              stack_pop_ff,
    output reg              pc_load_ff,
    output reg  [PC_W-1:0]  pc_value_ff,
    // Power-down
    output reg  [WD_W-1:0]  watchdog_counter_ff,
    output reg  [PRE_W-1:0] prescaler_ff,
    output reg              watchdog_expiry_flag_n_ff,
    output reg              powerdown_flag_n_ff,
    output reg              osc_stop_ff,
    // Sequencing
    output wire             busy
);
    // ------------------------------------------------------------------------
    // Datapath
    // ------------------------------------------------------------------------
    reg  [1:0]       state_ff;
    reg  [1:0]       nxt_state;
    wire [WIDTH-1:0] alu_result;
    wire             alu_carry;
    wire             alu_dc;
    wire             alu_zero;
    wire [WIDTH-1:0] alu_a;
    wire             take;
    wire             is_return;
    wire             is_rotate;
    // The subtract uses the literal as minuend; rotates work on the addressed file register.
    assign alu_a     = (instr_op == `OP_LIT_MINUS_ACC) ? instr_literal : file_rdata;
    // Busy covers the second return cycle and the whole of sleep.
    assign busy      = (state_ff != `ST_IDLE);
    assign take      = instr_valid & ~busy;
    assign is_return = (instr_op == `OP_SUB_EXIT) || (instr_op == `OP_LITERAL_EXIT);
    assign is_rotate = (instr_op == `OP_ROT_LEFT) || (instr_op == `OP_ROT_RIGHT);
    rot_sub_alu #(
        .WIDTH(WIDTH)
    ) u_alu (
        .operand_a       (alu_a),
        .acc_in          (acc_ff),
        .carry_in        (carry_in),
        .op_sel          (instr_op),
        .result          (alu_result),
        .carry_out       (alu_carry),
        .digit_carry_out (alu_dc),
        .zero_out        (alu_zero)
    );
    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            `ST_IDLE: begin
                if (take && (instr_op == `OP_SUB_EXIT || instr_op == `OP_LITERAL_EXIT)) begin
                    nxt_state = `ST_RET2; // [RULE1] [RULE2]
                end else if (take && instr_op == `OP_POWERDOWN) begin
                    nxt_state = `ST_SLEEP; // [RULE9]
                end
            end
            `ST_RET2: begin
                nxt_state = `ST_IDLE;
            end
            `ST_SLEEP: begin
                if (wake_event) begin
                    nxt_state = `ST_IDLE;
                end
            end
            default: begin
                nxt_state = `ST_IDLE;
            end
        endcase
    end
    // ------------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= `ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end
    // ------------------------------------------------------------------------
    // Accumulator and status flags
    // ------------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            acc_ff         <= `ACC_RESET;
            carry_ff       <= `FLAG_RESET;
            digit_carry_ff <= `FLAG_RESET;
            zero_ff        <= `FLAG_RESET;
        end else begin
            // Carry follows the external status bit unless an operation writes it.
            carry_ff <= carry_in;
            if (take) begin
                case (instr_op)
                    `OP_LITERAL_EXIT: begin
                        acc_ff <= instr_literal; // [RULE2]
                    end
                    `OP_ROT_LEFT, `OP_ROT_RIGHT: begin
                        carry_ff <= alu_carry; // [RULE3] [RULE5] [RULE10]
                        if (instr_dest == `DEST_ACC) begin
                            acc_ff <= alu_result; // [RULE4] [RULE5]
                        end
                    end
                    `OP_LIT_MINUS_ACC: begin
                        acc_ff         <= alu_result; // [RULE6]
                        carry_ff       <= alu_carry; // [RULE7]
                        digit_carry_ff <= alu_dc; // [RULE7]
                        zero_ff        <= alu_zero; // [RULE10]
                    end
                    default: begin
                        acc_ff <= acc_ff;
                    end
                endcase
            end
        end
    end
    // ------------------------------------------------------------------------
    // File register write port
    // ------------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            file_we_ff    <= 1'b0;
            file_waddr_ff <= `FILE_ADDR_RESET;
            file_wdata_ff <= {WIDTH{1'b0}};
        end else begin
            // The strobe lasts one cycle; address and data hold until the next write.
            file_we_ff <= 1'b0;
            if (take && is_rotate && instr_dest == `DEST_FILE) begin
                file_we_ff    <= 1'b1; // [RULE4] [RULE5]
                file_waddr_ff <= instr_file_addr;
                file_wdata_ff <= alu_result;
            end
        end
    end
    // ------------------------------------------------------------------------
    // Return path
    // ------------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            stack_pop_ff <= 1'b0;
            pc_load_ff   <= 1'b0;
            pc_value_ff  <= {PC_W{1'b0}};
        end else begin
            stack_pop_ff <= 1'b0;
            pc_load_ff   <= 1'b0;
            // Both returns pulse the pop in the cycle after the take, the one cycle the sequencer is busy in ST_RET2.
            if (take && is_return) begin
                stack_pop_ff <= 1'b1; // [RULE1] [RULE2]
                pc_load_ff   <= 1'b1;
                pc_value_ff  <= stack_top;
            end
        end
    end
    // ------------------------------------------------------------------------
    // Power-down and sleep
    // ------------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            watchdog_counter_ff       <= {WD_W{1'b0}};
            prescaler_ff              <= {PRE_W{1'b0}};
            watchdog_expiry_flag_n_ff <= `FLAG_N_RESET;
            powerdown_flag_n_ff       <= `FLAG_N_RESET;
            osc_stop_ff               <= 1'b0;
        end else begin
            // Only the wake event restarts the clock; instructions offered in sleep are dropped.
            if (state_ff == `ST_SLEEP && wake_event) begin
                osc_stop_ff <= 1'b0;
            end
            if (take && instr_op == `OP_POWERDOWN) begin
                watchdog_counter_ff       <= `WATCHDOG_CLEAR; // [RULE8]
                prescaler_ff              <= {PRE_W{1'b0}}; // [RULE8]
                watchdog_expiry_flag_n_ff <= 1'b1; // [RULE8]
                powerdown_flag_n_ff       <= 1'b0; // [RULE8]
                osc_stop_ff               <= 1'b1; // [RULE9]
            end
        end
    end
endmodule

// >>> logic/exec_unit_defs.vh
// Constants for the return, rotate, subtract and power-down execution unit.
`ifndef EXEC_UNIT_DEFS_VH
`define EXEC_UNIT_DEFS_VH
// ----------------------------------------------------------------------------
// Operation codes presented by the decoder
// ----------------------------------------------------------------------------
`define OP_NONE          3'h0
`define OP_SUB_EXIT      3'h1
`define OP_LITERAL_EXIT  3'h2
`define OP_ROT_LEFT      3'h3
`define OP_ROT_RIGHT     3'h4
`define OP_LIT_MINUS_ACC 3'h5
`define OP_POWERDOWN     3'h6
// ----------------------------------------------------------------------------
// Destination select, reset values and sequencer states
// ----------------------------------------------------------------------------
`define DEST_ACC         1'b0
`define DEST_FILE        1'b1
`define ACC_RESET        8'h00
`define WATCHDOG_CLEAR   8'h00
`define FLAG_RESET       1'b0
`define FLAG_N_RESET     1'b1
`define FILE_ADDR_RESET  7'h00
`define ST_IDLE          2'h0
`define ST_RET2          2'h1
`define ST_SLEEP         2'h2
`define MSB_POS          7
`define NIB_HI           3
`endif

// >>> logic/rot_sub_alu.v
// Combinational rotate-through-carry and literal-minus-accumulator datapath.
`timescale 1ns/1ps
`include "exec_unit_defs.vh"
module rot_sub_alu #(
    parameter WIDTH = 8
) (
    // Operands and operation select
    input  wire [WIDTH-1:0] operand_a,
    input  wire [WIDTH-1:0] acc_in,
    input  wire             carry_in,
    input  wire [2:0]       op_sel,
    // Results
    output reg  [WIDTH-1:0] result,
    output reg              carry_out,
    output reg              digit_carry_out,
    output wire             zero_out
);
    wire [WIDTH:0] diff_full;
    wire [4:0]     diff_low;
    assign diff_full = {1'b0, operand_a} - {1'b0, acc_in};
    assign diff_low  = {1'b0, operand_a[`NIB_HI:0]} - {1'b0, acc_in[`NIB_HI:0]};
    assign zero_out  = (result == {WIDTH{1'b0}});
    always @* begin
        result          = operand_a;
        carry_out       = carry_in;
        digit_carry_out = 1'b0;
        case (op_sel)
            `OP_ROT_LEFT: begin
                result    = {operand_a[WIDTH-2:0], carry_in};
                carry_out = operand_a[WIDTH-1];
            end
            `OP_ROT_RIGHT: begin
                result    = {carry_in, operand_a[WIDTH-1:1]};
                carry_out = operand_a[0];
            end
            `OP_LIT_MINUS_ACC: begin
                result          = diff_full[WIDTH-1:0];
                carry_out       = ~diff_full[WIDTH];
                digit_carry_out = ~diff_low[4];
            end
            default: begin
                result = operand_a;
            end
        endcase
    end
endmodule

// >>> sim/exec_unit_asserts.sv
// Concurrent checks on the execution unit ports.
`timescale 1ns/1ps
`include "exec_unit_defs.vh"
module exec_unit_asserts (
    input wire        clk, rst_n, instr_valid, instr_dest, wake_event, carry_in,
    input wire [2:0]  instr_op,
    input wire [7:0]  instr_literal, file_rdata, acc_ff, file_wdata_ff, watchdog_counter_ff, prescaler_ff,
    input wire [14:0] stack_top, pc_value_ff,
    input wire        carry_ff, digit_carry_ff, zero_ff, file_we_ff, stack_pop_ff, pc_load_ff,
    input wire        watchdog_expiry_flag_n_ff, powerdown_flag_n_ff, osc_stop_ff, busy
);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
sequence s_take(logic [2:0] op);
    rst_n && instr_valid && !busy && instr_op == op;
endsequence
sequence s_ret_done;
    pc_value_ff == $past(stack_top) && stack_pop_ff && pc_load_ff && busy ##1 !stack_pop_ff && !pc_load_ff && !busy;
endsequence
AST_RET_POP: assert property (s_take(`OP_SUB_EXIT) |=> s_ret_done)
    else $error("Return pop sequence wrong.");
AST_LIT_EXIT: assert property (s_take(`OP_LITERAL_EXIT) |=> acc_ff == $past(instr_literal) ##0 s_ret_done)
    else $error("Literal exit wrong.");
AST_ROL_CARRY: assert property (s_take(`OP_ROT_LEFT) |=> carry_ff == $past(file_rdata[7]))
    else $error("Rotate left carry wrong.");
AST_ROL_FILE: assert property (s_take(`OP_ROT_LEFT) ##0 instr_dest |=> file_we_ff && acc_ff == $past(acc_ff)
    && file_wdata_ff == {$past(file_rdata[6:0]), $past(carry_in)}) else $error("Rotate left write-back wrong.");
AST_ROR_ACC: assert property (s_take(`OP_ROT_RIGHT) ##0 !instr_dest |=> !file_we_ff
    && carry_ff == $past(file_rdata[0]) && acc_ff == {$past(carry_in), $past(file_rdata[7:1])})
    else $error("Rotate right wrong.");
AST_SUB: assert property (s_take(`OP_LIT_MINUS_ACC) |=> acc_ff == $past(instr_literal) - $past(acc_ff))
    else $error("Subtract result wrong.");
AST_SUB_FLAGS: assert property (s_take(`OP_LIT_MINUS_ACC) |=> carry_ff == ($past(acc_ff) <= $past(instr_literal))
    && digit_carry_ff == ($past(acc_ff[3:0]) <= $past(instr_literal[3:0]))) else $error("Subtract flags wrong.");
AST_ZERO: assert property (s_take(`OP_LIT_MINUS_ACC) |=> zero_ff == (acc_ff == 8'h00))
    else $error("Zero flag wrong.");
AST_SLEEP: assert property (s_take(`OP_POWERDOWN) |=> watchdog_counter_ff == 8'h00 && prescaler_ff == 8'h00
    && watchdog_expiry_flag_n_ff && !powerdown_flag_n_ff && osc_stop_ff && busy) else $error("Power-down wrong.");
AST_HALT: assert property (rst_n && osc_stop_ff && !wake_event |=> osc_stop_ff && busy
    && !stack_pop_ff && !file_we_ff) else $error("Sleep left without wake.");
endmodule
bind exec_unit exec_unit_asserts exec_unit_asserts_inst (.clk, .rst_n, .instr_valid, .instr_dest, .wake_event,
    .carry_in, .instr_op, .instr_literal, .file_rdata, .acc_ff, .file_wdata_ff, .watchdog_counter_ff, .prescaler_ff,
    .stack_top, .pc_value_ff, .carry_ff, .digit_carry_ff, .zero_ff, .file_we_ff, .stack_pop_ff, .pc_load_ff,
    .watchdog_expiry_flag_n_ff, .powerdown_flag_n_ff, .osc_stop_ff, .busy);

// >>> sim/tb_top.sv
// Random self-checking bench with a cycle model of the execution unit.
`timescale 1ns/1ps
`include "exec_unit_defs.vh"
module tb_top;
reg         clk = 1'b0, rst_n = 1'b0, go = 1'b0;
reg         instr_valid = 1'b0, instr_dest = 1'b0, wake_event = 1'b0, carry_in = 1'b0;
reg  [2:0]  instr_op = 3'h0;
reg  [7:0]  instr_literal = 8'h00, file_rdata = 8'h00, m_acc, m_wd, r;
reg  [6:0]  instr_file_addr = 7'h00, m_wa;
reg  [14:0] stack_top = 15'h0000, m_pcv;
reg  [15:0] seed = 16'h0041, a, b;
reg  [1:0]  m_st;
reg         m_c, m_dc, m_z, m_we, m_pop, m_pcl, m_to, m_pd, m_osc;
wire [7:0]  acc_ff, file_wdata_ff, watchdog_counter_ff, prescaler_ff;
wire [6:0]  file_waddr_ff;
wire [14:0] pc_value_ff;
wire        carry_ff, digit_carry_ff, zero_ff, file_we_ff, stack_pop_ff, pc_load_ff;
wire        watchdog_expiry_flag_n_ff, powerdown_flag_n_ff, osc_stop_ff, busy;
integer     bad_count = 0, compares = 0, i;
exec_unit exec_unit_inst (.clk, .rst_n, .instr_valid, .instr_op, .instr_literal, .instr_file_addr, .instr_dest,
    .instr_ready(1'b0), .file_rdata, .stack_top, .wake_event, .carry_in, .acc_ff, .carry_ff, .digit_carry_ff,
    .zero_ff, .file_we_ff, .file_waddr_ff, .file_wdata_ff, .stack_pop_ff, .pc_load_ff, .pc_value_ff,
    .watchdog_counter_ff, .prescaler_ff, .watchdog_expiry_flag_n_ff, .powerdown_flag_n_ff, .osc_stop_ff, .busy);
always #2.5 clk = ~clk;
function [15:0] lfsr(input [15:0] s);
    integer k;
    begin
        lfsr = s;
        for (k = 0; k < 16; k = k + 1) lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
endfunction
task chk(input string n, input [15:0] e, input [15:0] g);
    begin
        compares = compares + 1;
        if (e !== g) begin
            bad_count = bad_count + 1;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    end
endtask
task close_out;
    begin
        $display("Comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    end
endtask
always @(posedge clk) begin
    {m_we, m_pop, m_pcl} = 3'h0;
    if (!rst_n) begin
        {m_acc, m_c, m_dc, m_z, m_wa, m_wd, m_pcv, m_osc, m_st} = 44'h0;
        {m_to, m_pd} = 2'h3;
    end else begin
        m_c = carry_in;
        if (m_st == 2'h2) begin
            if (wake_event) {m_st, m_osc} = 3'h0;
        end else if (m_st == 2'h1) m_st = 2'h0;
        else if (instr_valid) case (instr_op)
            `OP_SUB_EXIT, `OP_LITERAL_EXIT: begin
                {m_pop, m_pcl, m_pcv, m_st} = {2'h3, stack_top, 2'h1};
                if (instr_op == `OP_LITERAL_EXIT) m_acc = instr_literal;
            end
            `OP_ROT_LEFT, `OP_ROT_RIGHT: begin
                r = instr_op == `OP_ROT_LEFT ? {file_rdata[6:0], carry_in} : {carry_in, file_rdata[7:1]};
                m_c = instr_op == `OP_ROT_LEFT ? file_rdata[7] : file_rdata[0];
                if (instr_dest) {m_we, m_wa, m_wd} = {1'b1, instr_file_addr, r};
                else m_acc = r;
            end
            `OP_LIT_MINUS_ACC: begin
                r = instr_literal - m_acc;
                {m_c, m_dc, m_z} = {m_acc <= instr_literal, m_acc[3:0] <= instr_literal[3:0], r == 8'h00};
                m_acc = r;
            end
            `OP_POWERDOWN: {m_to, m_pd, m_osc, m_st} = 5'h16;
            default: ;
        endcase
    end
end
always @(negedge clk) if (go) begin
    chk("acc", m_acc, acc_ff);
    chk("carry", {m_c, m_dc, m_z}, {carry_ff, digit_carry_ff, zero_ff});
    chk("file_write", {m_we, m_wa, m_wd}, {file_we_ff, file_waddr_ff, file_wdata_ff});
    chk("pc_value", m_pcv, pc_value_ff);
    chk("pulses", {m_pop, m_pcl}, {stack_pop_ff, pc_load_ff});
    chk("watchdog", 16'h0000, {watchdog_counter_ff, prescaler_ff});
    chk("sleep", {m_to, m_pd, m_osc, m_st != 2'h0}, {watchdog_expiry_flag_n_ff, powerdown_flag_n_ff, osc_stop_ff, busy});
end
initial begin
    @(posedge clk);
    go = 1'b1;
    repeat (4) @(posedge clk);
    for (i = 0; i < 4000; i = i + 1) begin
        a = lfsr(seed);
        b = lfsr(a);
        seed = b;
        rst_n <= i != 2000;
        instr_valid <= a[0] | a[1];
        instr_op <= a[4:2];
        instr_literal <= a[5] ? 8'h10 : a[15:8];
        instr_dest <= a[6];
        instr_file_addr <= b[6:0];
        file_rdata <= b[15:8];
        carry_in <= b[7];
        wake_event <= a[7] & b[0] & b[1];
        stack_top <= {b[6:0], a[15:8]};
        @(posedge clk);
    end
    close_out;
end
endmodule
